// >>> logic/vport_regs.vh
// register offsets, field positions and reset values of the video port output control
`ifndef VPORT_REGS_VH
`define VPORT_REGS_VH
// ----------------------------------------
// register offsets (subaddresses)
// ----------------------------------------
`define ADDR_GLOBAL_CTRL 8'h80
`define ADDR_EXP_ENABLE 8'h83
`define ADDR_IMG_SELECT 8'h84
`define ADDR_IMG_POLARITY 8'h85
`define ADDR_FIFO_FLAG_CTRL 8'h86
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_TASK_A_ENABLE 4
`define BIT_TASK_B_ENABLE 5
`define BIT_TIMING_FROM_SLICER 6
`define BIT_CLK_SEL_LO 0
`define BIT_CLK_SEL_HI 1
`define BIT_QUAL_GATED 2
`define BIT_QUAL_SCOPE 3
`define BIT_EXP_OE_LO 0
`define BIT_EXP_OE_HI 1
`define BIT_READY_SRC 2
`define BIT_EXP_PHASE_LO 4
`define BIT_EXP_PHASE_HI 5
`define BIT_GP0_SEL_LO 6
`define BIT_GP0_SEL_HI 7
`define BIT_GP0_POLARITY 4
`define BIT_GP0_SEL_TOP 5
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RST_GLOBAL_CTRL 8'h00
`define RST_EXP_ENABLE 8'h00
`define RST_IMG_SELECT 8'h00
`define RST_IMG_POLARITY 8'h00
`define RST_FIFO_FLAG_CTRL 8'h00
`define CLK_SEL_LLC 2'h0
`define CLK_SEL_EXPANSION_PORT_CLOCK 2'h1
`define CLK_SEL_HALF 2'h2
`define CLK_SEL_IMAGE_PORT_CLOCK 2'h3
`define EXP_OE_OFF 2'h0
`define EXP_OE_ON 2'h1
`define EXP_OE_PIN_LOW 2'h2
`define EXP_OE_PIN_HIGH 2'h3
`endif

// >>> logic/sync_two_stage.v
// two flip-flop synchroniser for a bundle of level inputs
`default_nettype none
module sync_two_stage #(
  parameter WIDTH = 1
) (
  input wire clk, // block clock
  input wire nrst, // async reset, active low
  input wire [WIDTH-1:0] d, // asynchronous levels
  output reg [WIDTH-1:0] q // synchronised levels
);
  reg [WIDTH-1:0] meta_r;
  // ----------------------------------------
  // two stages; the first feeds only the second
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync_two_stage
`default_nettype wire

// >>> logic/two_entry_buffer.v
// two-entry valid/ready buffer for expansion port words
`default_nettype none
module two_entry_buffer #(
  parameter WIDTH = 8
) (
  input wire clk, // block clock
  input wire nrst, // async reset, active low
  input wire [WIDTH-1:0] in_data, // word in
  input wire in_valid, // word in present
  output wire in_ready, // room for a word
  output wire [WIDTH-1:0] out_data, // oldest word
  output wire out_valid, // a word is held
  input wire out_ready // drain side accepts
);
  reg [WIDTH-1:0] mem_r [0:1];
  reg wptr_r;
  reg rptr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;
  // honest flags from the count
  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // ----------------------------------------
  // pointers and storage
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      count_r <= 2'h0;
      mem_r[0] <= {WIDTH{1'b0}};
      mem_r[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_r[wptr_r] <= in_data;
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      if (push & ~pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule // two_entry_buffer
`default_nettype wire

// >>> logic/video_port_output_control.v
// global control of scaler output, image port and expansion port
`include "vport_regs.vh"
`default_nettype none
module video_port_output_control #(
  parameter DATA_W = 8
) (
  input wire clk, // 25 MHz block clock
  input wire nrst, // async reset, active low
  input wire [7:0] reg_addr, // register subaddress
  input wire [7:0] reg_wdata, // write data
  input wire reg_we, // write strobe
  input wire reg_re, // read strobe
  output reg [7:0] reg_rdata, // read data, one cycle after strobe
  input wire line_locked_clock, // decoder clock, sampled
  input wire expansion_port_clock, // expansion clock, sampled
  input wire image_port_clock, // image port clock input level
  output reg image_port_clock_pin, // image port clock output level
  output reg image_port_clock_pin_oe, // high while driving the clock pin
  output reg backend_tick, // one-cycle back-end clock event
  input wire data_valid, // scaler output word valid
  input wire in_scaling_region, // scaler inside its window
  output reg output_data_qualifier, // qualifier pin level
  output reg task_a_run, // task set A running
  output reg task_b_run, // task set B running
  input wire scaler_field_id, // field from scaler window
  input wire scaler_vref, // vertical from scaler window
  input wire slicer_field_id, // field from slicer
  input wire slicer_vref, // vertical from slicer
  output reg output_field_id, // chosen output field
  output reg output_vref, // chosen output vertical
  output reg exp_clock_out, // phased expansion clock
  input wire exp_tristate_control_pin, // tristate control pin
  output reg exp_port_oe, // expansion outputs driven
  input wire task_a_active, // event handler task flag
  output reg exp_ready_output, // ready pin
  input wire [DATA_W-1:0] exp_data_in, // expansion port word
  input wire exp_data_valid, // expansion word present
  output reg [DATA_W-1:0] scaler_data, // word towards scaler
  output reg scaler_valid, // word towards scaler valid
  input wire scaler_ready, // scaler accepts word
  input wire sliced_data_flag, // sliced data framing
  input wire fifo_almost_filled, // output fifo flag
  input wire fifo_overflow, // output fifo flag
  input wire fifo_almost_full, // output fifo flag
  input wire fifo_almost_empty, // output fifo flag
  output reg general_output_zero // gp0 pin level
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [7:0] global_task_and_clock_control_r;
  reg [7:0] expansion_port_enable_and_phase_r;
  reg [7:0] image_port_signal_select_r;
  reg [7:0] image_port_polarity_r;
  reg [7:0] fifo_flag_control_r;
  reg [7:0] rdata_nxt;

  // plain byte writes at the printed subaddresses
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_task_and_clock_control_r <= `RST_GLOBAL_CTRL;
      expansion_port_enable_and_phase_r <= `RST_EXP_ENABLE;
      image_port_signal_select_r <= `RST_IMG_SELECT;
      image_port_polarity_r <= `RST_IMG_POLARITY;
      fifo_flag_control_r <= `RST_FIFO_FLAG_CTRL;
    end else if (reg_we) begin
      case (reg_addr)
        `ADDR_GLOBAL_CTRL: global_task_and_clock_control_r <= reg_wdata;
        `ADDR_EXP_ENABLE: expansion_port_enable_and_phase_r <= reg_wdata;
        `ADDR_IMG_SELECT: image_port_signal_select_r <= reg_wdata;
        `ADDR_IMG_POLARITY: image_port_polarity_r <= reg_wdata;
        `ADDR_FIFO_FLAG_CTRL: fifo_flag_control_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped subaddresses read zero
  always @* begin
    case (reg_addr)
      `ADDR_GLOBAL_CTRL: rdata_nxt = global_task_and_clock_control_r;
      `ADDR_EXP_ENABLE: rdata_nxt = expansion_port_enable_and_phase_r;
      `ADDR_IMG_SELECT: rdata_nxt = image_port_signal_select_r;
      `ADDR_IMG_POLARITY: rdata_nxt = image_port_polarity_r;
      `ADDR_FIFO_FLAG_CTRL: rdata_nxt = fifo_flag_control_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // field decode
  wire task_a_enable = global_task_and_clock_control_r[`BIT_TASK_A_ENABLE];
  wire task_b_enable = global_task_and_clock_control_r[`BIT_TASK_B_ENABLE];
  wire timing_from_slicer = global_task_and_clock_control_r[`BIT_TIMING_FROM_SLICER];
  wire [1:0] clk_sel_req = {global_task_and_clock_control_r[`BIT_CLK_SEL_HI],
                            global_task_and_clock_control_r[`BIT_CLK_SEL_LO]};
  wire qualifier_gated_clock_mode = global_task_and_clock_control_r[`BIT_QUAL_GATED];
  wire qualifier_scope_mode = global_task_and_clock_control_r[`BIT_QUAL_SCOPE];
  wire [1:0] exp_oe_mode = {expansion_port_enable_and_phase_r[`BIT_EXP_OE_HI],
                            expansion_port_enable_and_phase_r[`BIT_EXP_OE_LO]};
  wire ready_pin_source_select = expansion_port_enable_and_phase_r[`BIT_READY_SRC];
  wire exp_clock_phase_lo = expansion_port_enable_and_phase_r[`BIT_EXP_PHASE_LO];
  wire exp_clock_phase_hi = expansion_port_enable_and_phase_r[`BIT_EXP_PHASE_HI];
  wire [2:0] gp0_select = {fifo_flag_control_r[`BIT_GP0_SEL_TOP],
                           image_port_signal_select_r[`BIT_GP0_SEL_HI],
                           image_port_signal_select_r[`BIT_GP0_SEL_LO]};
  wire gp0_polarity = image_port_polarity_r[`BIT_GP0_POLARITY];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [4:0] pins_s;
  wire llc_s = pins_s[0];
  wire expansion_port_clock_s = pins_s[1];
  wire image_port_clock_s = pins_s[2];
  wire exp_tristate_control_pin_s = pins_s[3];
  wire xvalid_s = pins_s[4];
  wire [DATA_W-1:0] xdata_s;

  sync_two_stage #(.WIDTH(5)) u_sync_pins (
    .clk(clk),
    .nrst(nrst),
    .d({exp_data_valid, exp_tristate_control_pin, image_port_clock,
        expansion_port_clock, line_locked_clock}),
    .q(pins_s)
  );

  // data travels with its valid so both arrive together
  sync_two_stage #(.WIDTH(DATA_W)) u_sync_data (
    .clk(clk),
    .nrst(nrst),
    .d(exp_data_in),
    .q(xdata_s)
  );

  // ----------------------------------------
  // clock edge detection
  // ----------------------------------------
  reg llc_d_r;
  reg expansion_port_clock_d_r;
  reg image_port_clock_d_r;
  reg half_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      llc_d_r <= 1'b0;
      expansion_port_clock_d_r <= 1'b0;
      image_port_clock_d_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      llc_d_r <= llc_s;
      expansion_port_clock_d_r <= expansion_port_clock_s;
      image_port_clock_d_r <= image_port_clock_s;
      if (llc_s & ~llc_d_r) begin
        half_r <= ~half_r;
      end
    end
  end
  wire llc_rise = llc_s & ~llc_d_r;
  wire expansion_port_clock_rise = expansion_port_clock_s & ~expansion_port_clock_d_r;
  wire image_port_clock_rise = image_port_clock_s & ~image_port_clock_d_r;

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  reg [1:0] clk_sel_r;
  reg pin_level_nxt;
  reg tick_nxt;
  reg new_src_level;

  // safe switch point
  // the select is only taken over while the pin, the old and the new source are all low
  // and no tick is due, so no runt pulse can reach the pin; costs up to one period
  always @* begin
    case (clk_sel_req)
      `CLK_SEL_EXPANSION_PORT_CLOCK: new_src_level = expansion_port_clock_s;
      `CLK_SEL_IMAGE_PORT_CLOCK: new_src_level = 1'b0;
      default: new_src_level = llc_s;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_sel_r <= `CLK_SEL_LLC;
    end else if ((clk_sel_req != clk_sel_r) && !image_port_clock_pin && !pin_level_nxt &&
                 !tick_nxt && !new_src_level) begin
      clk_sel_r <= clk_sel_req;
    end
  end

  // pin level and back-end event
  // the half-rate option assumes the gated qualifier mode is set by software
  always @* begin
    case (clk_sel_r)
      `CLK_SEL_LLC: begin
        pin_level_nxt = llc_s;
        tick_nxt = llc_rise;
      end
      `CLK_SEL_EXPANSION_PORT_CLOCK: begin
        pin_level_nxt = expansion_port_clock_s;
        tick_nxt = expansion_port_clock_rise;
      end
      `CLK_SEL_HALF: begin
        pin_level_nxt = llc_s;
        tick_nxt = llc_rise & half_r;
      end
      default: begin
        pin_level_nxt = 1'b0;
        tick_nxt = image_port_clock_rise;
      end
    endcase
  end

  // ----------------------------------------
  // qualifier and task / timing control
  // ----------------------------------------
  reg qual_level;
  always @* begin
    if (qualifier_scope_mode) begin
      qual_level = in_scaling_region ? data_valid : 1'b1;
    end else begin
      qual_level = data_valid;
    end
  end

  // ----------------------------------------
  // expansion port enable, phase and ready
  // ----------------------------------------
  reg exp_oe_nxt;
  reg expansion_port_clock_delay_r;
  always @* begin
    case (exp_oe_mode)
      `EXP_OE_OFF: exp_oe_nxt = 1'b0;
      `EXP_OE_ON: exp_oe_nxt = 1'b1;
      `EXP_OE_PIN_LOW: exp_oe_nxt = ~exp_tristate_control_pin_s;
      default: exp_oe_nxt = exp_tristate_control_pin_s;
    endcase
  end

  // one extra stage stands in for the short output delay
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      expansion_port_clock_delay_r <= 1'b0;
    end else begin
      expansion_port_clock_delay_r <= expansion_port_clock_s;
    end
  end

  // words are taken on rising expansion clock edges while valid is seen
  wire buf_in_ready;
  wire buf_out_valid;
  wire [DATA_W-1:0] buf_out_data;
  wire buf_push = expansion_port_clock_rise & xvalid_s;
  wire scaler_take = scaler_valid & scaler_ready;
  wire out_stage_free = ~scaler_valid | scaler_ready;

  // ready paces the source so the buffer never drops a word
  two_entry_buffer #(.WIDTH(DATA_W)) u_exp_buffer (
    .clk(clk),
    .nrst(nrst),
    .in_data(xdata_s),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(out_stage_free)
  );

  // ----------------------------------------
  // general purpose output zero source
  // ----------------------------------------
  reg gp0_raw;
  reg field_nxt;
  always @* begin
    field_nxt = timing_from_slicer ? slicer_field_id : scaler_field_id;
    case (gp0_select)
      3'h0: gp0_raw = field_nxt;
      3'h1: gp0_raw = task_a_active;
      3'h2: gp0_raw = sliced_data_flag;
      3'h3: gp0_raw = 1'b0;
      3'h4: gp0_raw = fifo_almost_filled;
      3'h5: gp0_raw = fifo_overflow;
      3'h6: gp0_raw = fifo_almost_full;
      default: gp0_raw = fifo_almost_empty;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      image_port_clock_pin <= 1'b0;
      image_port_clock_pin_oe <= 1'b0;
      backend_tick <= 1'b0;
      output_data_qualifier <= 1'b0;
      task_a_run <= 1'b0;
      task_b_run <= 1'b0;
      output_field_id <= 1'b0;
      output_vref <= 1'b0;
      exp_clock_out <= 1'b0;
      exp_port_oe <= 1'b0;
      exp_ready_output <= 1'b0;
      scaler_data <= {DATA_W{1'b0}};
      scaler_valid <= 1'b0;
      general_output_zero <= 1'b0;
    end else begin
      if (reg_re) begin
        reg_rdata <= rdata_nxt;
      end
      image_port_clock_pin <= pin_level_nxt;
      image_port_clock_pin_oe <= (clk_sel_r != `CLK_SEL_IMAGE_PORT_CLOCK);
      backend_tick <= tick_nxt;
      output_data_qualifier <= qualifier_gated_clock_mode ? (qual_level & tick_nxt) : qual_level;
      task_a_run <= task_a_enable;
      task_b_run <= task_b_enable;
      output_field_id <= field_nxt;
      output_vref <= timing_from_slicer ? slicer_vref : scaler_vref;
      exp_clock_out <= (exp_clock_phase_hi ? expansion_port_clock_delay_r : expansion_port_clock_s) ^ exp_clock_phase_lo;
      exp_port_oe <= exp_oe_nxt;
      exp_ready_output <= ready_pin_source_select ? buf_in_ready : task_a_active;
      if (out_stage_free) begin
        scaler_valid <= buf_out_valid;
        if (buf_out_valid) begin
          scaler_data <= buf_out_data;
        end
      end else if (scaler_take) begin
        scaler_valid <= 1'b0;
      end
      general_output_zero <= gp0_raw ^ gp0_polarity;
    end
  end
endmodule // video_port_output_control
`default_nettype wire

// >>> test/vport_checker_asserts.sv
// concurrent port checks for the video port output control block
`default_nettype none
module vport_checker #(
  parameter DATA_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic task_a_run,
  input wire logic task_b_run,
  input wire logic scaler_vref,
  input wire logic slicer_vref,
  input wire logic output_vref,
  input wire logic data_valid,
  input wire logic in_scaling_region,
  input wire logic output_data_qualifier,
  input wire logic exp_tristate_control_pin,
  input wire logic exp_port_oe,
  input wire logic task_a_active,
  input wire logic exp_ready_output,
  input wire logic [DATA_W-1:0] scaler_data,
  input wire logic scaler_valid,
  input wire logic scaler_ready,
  input wire logic backend_tick,
  input wire logic sliced_data_flag,
  input wire logic fifo_almost_filled,
  input wire logic fifo_overflow,
  input wire logic fifo_almost_full,
  input wire logic fifo_almost_empty,
  input wire logic general_output_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] g_r, e_r, s_r, p_r, f_r;
  logic gm;
  wire [2:0] gs = {f_r[5], s_r[7:6]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow of the control registers, updated on the same edge as the block's
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g_r <= 8'h00;
      e_r <= 8'h00;
      s_r <= 8'h00;
      p_r <= 8'h00;
      f_r <= 8'h00;
    end else if (reg_we) begin
      case (reg_addr)
        8'h80: g_r <= reg_wdata;
        8'h83: e_r <= reg_wdata;
        8'h84: s_r <= reg_wdata;
        8'h85: p_r <= reg_wdata;
        8'h86: f_r <= reg_wdata;
        default: ;
      endcase
    end
  end
  // gp0 source for the codes that need no timing knowledge
  always_comb begin
    case (gs)
      3'h2: gm = sliced_data_flag;
      3'h4: gm = fifo_almost_filled;
      3'h5: gm = fifo_overflow;
      3'h6: gm = fifo_almost_full;
      3'h7: gm = fifo_almost_empty;
      default: gm = 1'b0;
    endcase
  end
  sequence s_pin_steady;
    (e_r[1] && $stable(exp_tristate_control_pin) && $stable(e_r))[*5];
  endsequence
  property p_task;
    task_a_run == $past(g_r[4]) && task_b_run == $past(g_r[5]);
  endproperty
  property p_vref;
    $past(nrst) |-> output_vref == $past(g_r[6] ? slicer_vref : scaler_vref);
  endproperty
  property p_qual;
    !$past(g_r[2]) |-> output_data_qualifier ==
      $past(g_r[3] ? (in_scaling_region ? data_valid : 1'b1) : data_valid);
  endproperty
  property p_oe_sw;
    !$past(e_r[1]) |-> exp_port_oe == $past(e_r[0]);
  endproperty
  property p_oe_pin;
    s_pin_steady |-> exp_port_oe == (e_r[0] ? exp_tristate_control_pin : !exp_tristate_control_pin);
  endproperty
  property p_rdy_task;
    !$past(e_r[2]) |-> exp_ready_output == $past(task_a_active);
  endproperty
  property p_hold;
    scaler_valid && !scaler_ready |=> scaler_valid && $stable(scaler_data);
  endproperty
  property p_tick;
    backend_tick |=> !backend_tick;
  endproperty
  property p_gp0;
    $past(gs) >= 3'h2 |-> general_output_zero == $past(p_r[4] ^ gm);
  endproperty
  a_task: assert property (p_task) else $error("task run differs from enable");
  a_vref: assert property (p_vref) else $error("vertical timing source wrong");
  a_qual: assert property (p_qual) else $error("qualifier scope wrong");
  a_oe_sw: assert property (p_oe_sw) else $error("software output enable wrong");
  a_oe_pin: assert property (p_oe_pin) else $error("pin output enable wrong");
  a_rdy_task: assert property (p_rdy_task) else $error("ready not task flag");
  a_hold: assert property (p_hold) else $error("stalled word not held");
  a_tick: assert property (p_tick) else $error("back-end tick too long");
  a_gp0: assert property (p_gp0) else $error("gp0 source wrong");
endmodule // vport_checker
bind video_port_output_control vport_checker #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire

// >>> test/exp_source.sv
// expansion port source model: one frame of words, paced by the ready pin
`default_nettype none
module exp_source #(
  parameter logic [7:0] BASE = 8'hA0,
  parameter int COUNT = 4
) (
  input wire logic go, // start a frame
  input wire logic exp_ready_output, // device ready pin
  output logic expansion_port_clock, // link clock, still between frames
  output logic [7:0] exp_data_in, // word
  output logic exp_data_valid, // word present
  output logic done // frame sent
);
  timeunit 1ns;
  timeprecision 1ps;
  int w;
  initial begin
    expansion_port_clock = 1'b0;
    exp_data_valid = 1'b0;
    exp_data_in = 8'h00;
    done = 1'b0;
    forever begin
      wait (go);
      for (int i = 0; i < COUNT; i++) begin
        exp_data_in = BASE + 8'(i);
        exp_data_valid = 1'b1;
        #120;
        // hold word
        // clock stands still until ready, so a held word is never pushed twice
        w = 0;
        while (!exp_ready_output && w < 2000) begin
          #40;
          w++;
        end
        #40 expansion_port_clock = 1'b1;
        #160 expansion_port_clock = 1'b0;
      end
      exp_data_valid = 1'b0;
      exp_data_in = ~exp_data_in; // released line shows no stale word
      done = 1'b1;
      wait (!go);
      done = 1'b0;
    end
  end
endmodule // exp_source
`default_nettype wire

// >>> test/video_port_output_control_test.sv
// self-checking bench for the video port output control block
`default_nettype none
module video_port_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, reg_we = 0, reg_re = 0, go = 0, done;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, exp_data_in, scaler_data;
  logic line_locked_clock = 0, expansion_port_clock, image_port_clock = 0;
  logic image_port_clock_pin, image_port_clock_pin_oe, backend_tick, exp_clock_out;
  logic data_valid = 0, in_scaling_region = 0, output_data_qualifier, task_a_run, task_b_run;
  logic scaler_field_id = 1, scaler_vref = 0, slicer_field_id = 0, slicer_vref = 1;
  logic output_field_id, output_vref, exp_tristate_control_pin = 0, exp_port_oe;
  logic task_a_active = 0, exp_ready_output, exp_data_valid, scaler_valid, scaler_ready = 0;
  logic sliced_data_flag = 0, fifo_almost_filled = 0, fifo_overflow = 0;
  logic fifo_almost_full = 0, fifo_almost_empty = 0, general_output_zero;
  int err_total = 0, compares = 0, n;
  always #20 clk = ~clk;
  always #100 line_locked_clock = ~line_locked_clock; // unrelated decoder clock
  video_port_output_control #(.DATA_W(8)) dut (.*);
  exp_source src (.*);
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1;
    @(negedge clk);
    reg_we = 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1;
    @(negedge clk);
    reg_re = 0;
    chk(reg_rdata, exp);
  endtask
  // counts back-end ticks, or qualifier-high cycles, over 100 cycles
  task automatic count_hi(input bit qual, output int c);
    c = 0;
    repeat (100) begin
      @(negedge clk);
      c += qual ? output_data_qualifier : backend_tick;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] ad [5];
    logic [7:0] dv [5];
    ad = '{8'h80, 8'h83, 8'h84, 8'h85, 8'h86};
    dv = '{8'h34, 8'h35, 8'hC0, 8'h10, 8'h20};
    for (int i = 0; i < 5; i++) rd_chk(ad[i], 8'h00);
    for (int i = 0; i < 5; i++) wr(ad[i], dv[i]);
    wr(8'h81, 8'hFF);
    for (int i = 0; i < 5; i++) rd_chk(ad[i], dv[i]);
    rd_chk(8'h81, 8'h00);
    for (int i = 0; i < 5; i++) wr(ad[i], 8'h00);
  endtask
  task automatic t_task();
    wr(8'h80, 8'h10);
    @(negedge clk);
    chk({5'h0, output_field_id, task_b_run, task_a_run}, 8'h05);
    wr(8'h80, 8'h60);
    @(negedge clk);
    chk({4'h0, output_field_id, task_b_run, task_a_run, output_vref}, 8'h05);
    wr(8'h80, 8'h00);
    @(negedge clk);
    chk({4'h0, output_field_id, task_b_run, task_a_run, output_vref}, 8'h08);
  endtask
  task automatic t_qual();
    for (int i = 0; i < 8; i++) begin
      wr(8'h80, {4'h0, i[2], 3'h0});
      {in_scaling_region, data_valid} = i[1:0];
      repeat (2) @(negedge clk);
      chk({7'h0, output_data_qualifier}, {7'h0, i[2] ? (i[1] ? i[0] : 1'b1) : i[0]});
    end
    wr(8'h80, 8'h04);
    data_valid = 1;
    repeat (10) @(negedge clk);
    count_hi(1, n);
    chk({7'h0, n >= 19 && n <= 21}, 8'h01);
  endtask
  task automatic t_clk();
    wr(8'h80, 8'h00);
    repeat (10) @(negedge clk);
    count_hi(0, n);
    chk({7'h0, n >= 19 && n <= 21}, 8'h01);
    // half-rate back end is only chosen with the gated qualifier mode
    wr(8'h80, 8'h06);
    repeat (10) @(negedge clk);
    count_hi(0, n);
    chk({7'h0, n >= 9 && n <= 11}, 8'h01);
    wr(8'h80, 8'h01);
    repeat (10) @(negedge clk);
    count_hi(0, n);
    chk({7'h0, n == 0 && image_port_clock_pin == 1'b0}, 8'h01);
    wr(8'h80, 8'h03);
    repeat (10) @(negedge clk);
    chk({7'h0, image_port_clock_pin_oe}, 8'h00);
    // back end follows the image-port clock input: six rising edges, six ticks
    n = 0;
    for (int k = 0; k < 48; k++) begin
      @(negedge clk);
      image_port_clock = k[2];
      n += backend_tick;
    end
    chk({7'h0, n == 6}, 8'h01);
    wr(8'h80, 8'h00);
    repeat (10) @(negedge clk);
    chk({7'h0, image_port_clock_pin_oe}, 8'h01);
  endtask
  task automatic t_oe();
    for (int m = 0; m < 4; m++) for (int p = 0; p < 2; p++) begin
      wr(8'h83, {2'h0, m[1:0], 2'h0, m[1:0]});
      exp_tristate_control_pin = p[0];
      repeat (5) @(negedge clk);
      chk({6'h0, exp_clock_out, exp_port_oe},
          {6'h0, m[0], m == 1 || (m == 2 && p == 0) || (m == 3 && p == 1)});
    end
  endtask
  task automatic t_gp0();
    logic [7:0] s;
    for (int v = 0; v < 2; v++) begin
      s = v ? 8'hA2 : 8'h55; // bit 3 stands for the constant-zero code
      {fifo_almost_empty, fifo_almost_full, fifo_overflow, fifo_almost_filled} = s[7:4];
      {sliced_data_flag, task_a_active, scaler_field_id} = s[2:0];
      for (int c = 0; c < 8; c++) for (int p = 0; p < 2; p++) begin
        wr(8'h84, {c[1:0], 6'h00});
        wr(8'h86, {2'h0, c[2], 5'h00});
        wr(8'h85, {3'h0, p[0], 4'h0});
        repeat (4) @(negedge clk);
        chk({7'h0, general_output_zero}, {7'h0, s[c] ^ p[0]});
      end
    end
  endtask
  task automatic t_stream();
    wr(8'h83, 8'h00);
    task_a_active = 1;
    repeat (3) @(negedge clk);
    chk({7'h0, exp_ready_output}, 8'h01);
    task_a_active = 0;
    repeat (3) @(negedge clk);
    chk({7'h0, exp_ready_output}, 8'h00);
    wr(8'h83, 8'h04);
    @(negedge clk);
    chk({7'h0, exp_ready_output}, 8'h01);
    go = 1;
    n = 0;
    while (exp_ready_output !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      err_total++;
      give_verdict();
    end
    repeat (40) @(negedge clk);
    chk({6'h0, scaler_valid, done}, 8'h02);
    chk(scaler_data, 8'hA0);
    scaler_ready = 1;
    for (int i = 0; i < 4; i++) begin
      n = 0;
      while (scaler_valid !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (n == 100) begin
        err_total++;
        give_verdict();
      end
      chk(scaler_data, 8'hA0 + 8'(i));
      @(negedge clk);
    end
    chk({6'h0, done, exp_ready_output}, 8'h03);
    go = 0;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1;
    t_regs();
    t_task();
    t_qual();
    t_clk();
    t_oe();
    t_gp0();
    t_stream();
    give_verdict();
  end
endmodule // video_port_output_control_test
`default_nettype wire
